// *** src/sltc_regs.svh ***
/*
 Register indices, field positions, reset values and link constants of the
 serial link transmit control block. Assumes a 32-bit AXI4-Lite bus with
 each register in one 32-bit word at four times its index.
*/
`ifndef SLTC_REGS_SVH
`define SLTC_REGS_SVH

`define SLTC_ADDR_W 12
`define SLTC_IDX_W 10
`define SLTC_IDX_CTRL1 10'h201
`define SLTC_IDX_CTRL2 10'h202
`define SLTC_IDX_DID 10'h203
`define SLTC_IDX_CTRL3 10'h204
`define SLTC_IDX_STATUS 10'h205
`define SLTC_IDX_IRQ_STS 10'h280
`define SLTC_IDX_IRQ_MASK 10'h281

`define SLTC_RST_CTRL1 8'h0F
`define SLTC_RST_CTRL2 8'h00
`define SLTC_RST_DID 8'h00
`define SLTC_RST_CTRL3 8'h00

`define SLTC_C1_SCR 7
`define SLTC_C1_K_HI 6
`define SLTC_C1_K_LO 2
`define SLTC_C1_RATE 1
`define SLTC_C1_EN 0
`define SLTC_C2_P54 7
`define SLTC_C2_SSEL 6
`define SLTC_C2_TEST_HI 3
`define SLTC_C2_TEST_LO 0
`define SLTC_C3_FCH_HI 1
`define SLTC_C3_FCH_LO 0
`define SLTC_ST_LINKUP 6
`define SLTC_ST_SYNC 5
`define SLTC_ST_REALIGN 4
`define SLTC_ST_ALIGN 3
`define SLTC_ST_PLL 2

`define SLTC_IRQ_W 4
`define SLTC_EV_ALIGN 0
`define SLTC_EV_REALIGN 1
`define SLTC_EV_UP 2
`define SLTC_EV_DOWN 3

`define SLTC_RATE_1X 4'h4
`define SLTC_RATE_125X 4'h5
`define SLTC_RATE_2X 4'h8
`define SLTC_RATE_25X 4'hA

`define SLTC_FCH_K28_7 2'h0
`define SLTC_FCH_K28_1 2'h1
`define SLTC_FCH_K28_5 2'h2
`define SLTC_K28_7 8'hFC
`define SLTC_K28_1 8'h3C
`define SLTC_K28_5 8'hBC
`define SLTC_F_DATA 8'hFC

`define SLTC_TEST_LAST 4'hB
`define SLTC_ILA_LAST_MF 2'h3
`define SLTC_DID_MF 2'h1

`define SLTC_RESP_OKAY 2'h0
`define SLTC_RESP_SLVERR 2'h2

`endif

// *** src/sltc_pkg.sv ***
/*
 Types of the serial link transmit control block: link states, test
 pattern codes, the control bundle to the transmitter and the state record.
 Assumes sltc_regs.svh is compiled alongside.
*/
`include "sltc_regs.svh"
package sltc_pkg;
    typedef enum logic [1:0] {
        LS_IDLE = 2'h0,
        LS_CGS = 2'h1,
        LS_ILA = 2'h3,
        LS_DATA = 2'h2
    } sltc_link_t;

    typedef enum logic [3:0] {
        TEST_OFF = 4'h0, TEST_PRBS7 = 4'h1, TEST_PRBS15 = 4'h2, TEST_PRBS23 = 4'h3,
        TEST_RAMP = 4'h4, TEST_TRANSPORT = 4'h5, TEST_D21_5 = 4'h6,
        TEST_K28_5 = 4'h7, TEST_ILA_RPT = 4'h8, TEST_MRPAT = 4'h9,
        TEST_LOW = 4'hA, TEST_HIGH = 4'hB
    } sltc_test_t;

    typedef struct packed {
        logic tx_resetn;
        logic serdes_pd;
        logic clk_gate_en;
        logic scramble;
        logic [4:0] k_m1;
        logic [3:0] rate_q;
        sltc_test_t test;
        logic [7:0] eof_char;
    } sltc_tx_ctrl_t;

    typedef struct packed {
        logic aw_ok;
        logic [`SLTC_ADDR_W-1:0] aw_addr;
        logic w_ok;
        logic [7:0] w_data;
        logic w_en;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] did;
        logic [7:0] ctrl3;
        logic multiframe_phase_flag;
        logic realigned;
        logic armed;
        logic en_prev;
        logic [`SLTC_IRQ_W-1:0] irq_sts;
        logic [`SLTC_IRQ_W-1:0] irq_mask;
        sltc_link_t link;
        logic [4:0] frame_cnt;
        logic [1:0] mf_cnt;
        logic sync_n;
        logic [7:0] prev_octet;
        logic prev_rep;
        logic eof_rep;
        logic did_valid;
        logic [7:0] did_out;
        sltc_tx_ctrl_t tx;
    } sltc_state_t;
endpackage : sltc_pkg

// *** src/sltc_top.sv ***
/*
 Register bank and link sequencing for the serial link transmitter: AXI4-Lite
 slave, transmitter control bundle, link state machine, status and interrupt.
 Assumes frame strobes, SYSREF and sync inputs synchronous to MCLK.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sltc_regs.svh"

// Function
// - Scramble bit enables scrambling, reset off
// - Field holds frames per multiframe minus one
// - Rate bit: one or two times sample rate
// - Disabled link holds transmitter reset, powered down
// - Five-quarter bit scales bit rate by 1.25
// - Select bit routes single-ended or differential sync
// - Test codes zero to five select sources
// - Test codes six to eleven; rest reserved
// - Identifier sent in second alignment multiframe
// - Frame-end field picks K28.7, K28.1, K28.5
// - Frame-end comma replaces octets opportunistically
// - Link-up flag only in data transmission state
// - First SYSREF after enable sets phase flag
module sltc_top
    import sltc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic [`SLTC_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [`SLTC_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic SYNC_SINGLE_ENDED_N,
    input wire logic SYNC_DIFFERENTIAL_N,
    input wire logic SYSREF,
    input wire logic PLL_LOCKED,
    input wire logic FRAME_STROBE,
    input wire logic [7:0] LAST_OCTET,
    output sltc_tx_ctrl_t TX_CTRL,
    output logic SYNC_N_OUT,
    output logic LINK_UP,
    output logic EOF_REPLACE,
    output logic ILA_DID_VALID,
    output logic [7:0] ILA_DID,
    output logic IRQ
);

    sltc_state_t s_q;
    sltc_state_t s_d;
    logic mf_end;
    logic [`SLTC_IRQ_W-1:0] ev;

    function automatic logic [3:0] rate_code(input logic ddr, input logic p54);
        if (ddr) begin
            rate_code = p54 ? `SLTC_RATE_25X : `SLTC_RATE_2X;
        end else begin
            rate_code = p54 ? `SLTC_RATE_125X : `SLTC_RATE_1X;
        end
    endfunction : rate_code

    function automatic logic [7:0] eof_code(input logic [1:0] sel);
        case (sel)
            `SLTC_FCH_K28_1: eof_code = `SLTC_K28_1;
            `SLTC_FCH_K28_5: eof_code = `SLTC_K28_5;
            default: eof_code = `SLTC_K28_7;
        endcase
    endfunction : eof_code

    // Reserved test codes fall back to normal data rather than an unknown source
    function automatic sltc_test_t test_code(input logic [3:0] code);
        test_code = (code > `SLTC_TEST_LAST) ? TEST_OFF : sltc_test_t'(code);
    endfunction : test_code

    function automatic sltc_tx_ctrl_t make_tx(input logic [7:0] c1, input logic [7:0] c2,
                                              input logic [7:0] c3);
        make_tx.tx_resetn = c1[`SLTC_C1_EN];
        make_tx.serdes_pd = ~c1[`SLTC_C1_EN];
        make_tx.clk_gate_en = c1[`SLTC_C1_EN];
        make_tx.scramble = c1[`SLTC_C1_SCR];
        make_tx.k_m1 = c1[`SLTC_C1_K_HI:`SLTC_C1_K_LO];
        make_tx.rate_q = rate_code(c1[`SLTC_C1_RATE], c2[`SLTC_C2_P54]);
        make_tx.test = test_code(c2[`SLTC_C2_TEST_HI:`SLTC_C2_TEST_LO]);
        make_tx.eof_char = eof_code(c3[`SLTC_C3_FCH_HI:`SLTC_C3_FCH_LO]);
    endfunction : make_tx

    function automatic logic [`SLTC_IDX_W-1:0] reg_index(input logic [`SLTC_ADDR_W-1:0] a);
        reg_index = a[`SLTC_ADDR_W-1:2];
    endfunction : reg_index

    function automatic logic reg_hit(input logic [`SLTC_IDX_W-1:0] idx);
        reg_hit = (idx == `SLTC_IDX_CTRL1) || (idx == `SLTC_IDX_CTRL2) ||
                  (idx == `SLTC_IDX_DID) || (idx == `SLTC_IDX_CTRL3) ||
                  (idx == `SLTC_IDX_STATUS) || (idx == `SLTC_IDX_IRQ_STS) ||
                  (idx == `SLTC_IDX_IRQ_MASK);
    endfunction : reg_hit

    function automatic sltc_state_t reset_state();
        reset_state = '0;
        reset_state.ctrl1 = `SLTC_RST_CTRL1;
        reset_state.ctrl2 = `SLTC_RST_CTRL2;
        reset_state.did = `SLTC_RST_DID;
        reset_state.ctrl3 = `SLTC_RST_CTRL3;
        reset_state.armed = 1'b1;
        reset_state.en_prev = 1'b1;
        reset_state.sync_n = 1'b1;
        reset_state.link = LS_IDLE;
        reset_state.tx = make_tx(`SLTC_RST_CTRL1, `SLTC_RST_CTRL2, `SLTC_RST_CTRL3);
    endfunction : reset_state

    // Status bits come live from state and the PLL_LOCKED input; unused bits read zero
    function automatic logic [7:0] status_byte(input sltc_state_t s, input logic pll);
        status_byte = '0;
        status_byte[`SLTC_ST_LINKUP] = (s.link == LS_DATA);
        status_byte[`SLTC_ST_SYNC] = s.sync_n;
        status_byte[`SLTC_ST_REALIGN] = s.realigned;
        status_byte[`SLTC_ST_ALIGN] = s.multiframe_phase_flag;
        status_byte[`SLTC_ST_PLL] = pll;
    endfunction : status_byte

    always_comb begin
        mf_end = FRAME_STROBE && (s_q.frame_cnt == s_q.ctrl1[`SLTC_C1_K_HI:`SLTC_C1_K_LO]);
        ev = '0;
        s_d = s_q;
        s_d.eof_rep = 1'b0;

        if (S_AXI_AWVALID && !s_q.aw_ok && !s_q.bvalid) begin
            s_d.aw_ok = 1'b1;
            s_d.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !s_q.w_ok && !s_q.bvalid) begin
            s_d.w_ok = 1'b1;
            s_d.w_data = S_AXI_WDATA[7:0];
            s_d.w_en = S_AXI_WSTRB[0];
        end
        if (s_q.bvalid && S_AXI_BREADY) begin
            s_d.bvalid = 1'b0;
        end
        // Address and data may arrive in either order; commit once both are held
        if (s_q.aw_ok && s_q.w_ok) begin
            s_d.aw_ok = 1'b0;
            s_d.w_ok = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = reg_hit(reg_index(s_q.aw_addr)) ? `SLTC_RESP_OKAY : `SLTC_RESP_SLVERR;
            if (s_q.w_en) begin
                case (reg_index(s_q.aw_addr))
                    `SLTC_IDX_CTRL1: s_d.ctrl1 = s_q.w_data;
                    `SLTC_IDX_CTRL2: s_d.ctrl2 = s_q.w_data;
                    `SLTC_IDX_DID: s_d.did = s_q.w_data;
                    `SLTC_IDX_CTRL3: s_d.ctrl3 = s_q.w_data;
                    `SLTC_IDX_STATUS: begin
                        if (s_q.w_data[`SLTC_ST_ALIGN]) begin
                            s_d.multiframe_phase_flag = 1'b0;
                        end
                        if (s_q.w_data[`SLTC_ST_REALIGN]) begin
                            s_d.realigned = 1'b0;
                        end
                    end
                    `SLTC_IDX_IRQ_STS: s_d.irq_sts = s_q.irq_sts & ~s_q.w_data[`SLTC_IRQ_W-1:0];
                    `SLTC_IDX_IRQ_MASK: s_d.irq_mask = s_q.w_data[`SLTC_IRQ_W-1:0];
                    default: ;
                endcase
            end
        end

        if (S_AXI_ARVALID && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = reg_hit(reg_index(S_AXI_ARADDR)) ? `SLTC_RESP_OKAY : `SLTC_RESP_SLVERR;
            case (reg_index(S_AXI_ARADDR))
                `SLTC_IDX_CTRL1: s_d.rdata = s_q.ctrl1;
                `SLTC_IDX_CTRL2: s_d.rdata = s_q.ctrl2;
                `SLTC_IDX_DID: s_d.rdata = s_q.did;
                `SLTC_IDX_CTRL3: s_d.rdata = s_q.ctrl3;
                `SLTC_IDX_STATUS: s_d.rdata = status_byte(s_q, PLL_LOCKED);
                `SLTC_IDX_IRQ_STS: s_d.rdata = {{(8-`SLTC_IRQ_W){1'b0}}, s_q.irq_sts};
                `SLTC_IDX_IRQ_MASK: s_d.rdata = {{(8-`SLTC_IRQ_W){1'b0}}, s_q.irq_mask};
                default: s_d.rdata = '0;
            endcase
        end else if (s_q.rvalid && S_AXI_RREADY) begin
            s_d.rvalid = 1'b0;
        end

        s_d.sync_n = s_q.ctrl2[`SLTC_C2_SSEL] ? SYNC_DIFFERENTIAL_N : SYNC_SINGLE_ENDED_N;
        s_d.en_prev = s_q.ctrl1[`SLTC_C1_EN];

        // Flag sets come after the software clears above, so a coincident event wins
        if (!s_q.ctrl1[`SLTC_C1_EN]) begin
            s_d.link = LS_IDLE;
            s_d.frame_cnt = '0;
            s_d.mf_cnt = '0;
            s_d.armed = 1'b0;
            s_d.prev_rep = 1'b0;
        end else begin
            if (!s_q.en_prev) begin
                s_d.armed = 1'b1;
            end
            if (SYSREF) begin
                if (s_q.armed || !s_q.en_prev) begin
                    s_d.multiframe_phase_flag = 1'b1;
                    s_d.armed = 1'b0;
                    ev[`SLTC_EV_ALIGN] = 1'b1;
                end else begin
                    s_d.realigned = 1'b1;
                    ev[`SLTC_EV_REALIGN] = 1'b1;
                end
            end
            if (FRAME_STROBE) begin
                s_d.frame_cnt = mf_end ? '0 : s_q.frame_cnt + 5'h01;
            end
            unique case (s_q.link)
                LS_IDLE: s_d.link = LS_CGS;
                LS_CGS: begin
                    if (s_q.sync_n && mf_end) begin
                        s_d.link = LS_ILA;
                        s_d.mf_cnt = '0;
                    end
                end
                LS_ILA: begin
                    if (!s_q.sync_n) begin
                        s_d.link = LS_CGS;
                    end else if (mf_end) begin
                        if (s_q.mf_cnt == `SLTC_ILA_LAST_MF) begin
                            s_d.link = LS_DATA;
                        end else begin
                            s_d.mf_cnt = s_q.mf_cnt + 2'h1;
                        end
                    end
                end
                LS_DATA: begin
                    if (!s_q.sync_n) begin
                        s_d.link = LS_CGS;
                    end else if (FRAME_STROBE) begin
                        // Scrambled data only replaces an octet that already looks like F
                        if (s_q.ctrl1[`SLTC_C1_SCR]) begin
                            s_d.eof_rep = (LAST_OCTET == `SLTC_F_DATA);
                        end else begin
                            s_d.eof_rep = (LAST_OCTET == s_q.prev_octet) && !s_q.prev_rep;
                        end
                        s_d.prev_octet = LAST_OCTET;
                        s_d.prev_rep = s_d.eof_rep;
                    end
                end
            endcase
        end

        s_d.did_valid = (s_d.link == LS_ILA) && (s_d.mf_cnt == `SLTC_DID_MF);
        s_d.did_out = s_q.did;
        ev[`SLTC_EV_UP] = (s_d.link == LS_DATA) && (s_q.link != LS_DATA);
        ev[`SLTC_EV_DOWN] = (s_q.link == LS_DATA) && (s_d.link != LS_DATA);
        s_d.irq_sts = s_d.irq_sts | ev;
        s_d.tx = make_tx(s_d.ctrl1, s_d.ctrl2, s_d.ctrl3);
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            s_q <= reset_state();
        end else begin
            s_q <= s_d;
        end
    end

    assign S_AXI_AWREADY = !s_q.aw_ok && !s_q.bvalid;
    assign S_AXI_WREADY = !s_q.w_ok && !s_q.bvalid;
    assign S_AXI_BVALID = s_q.bvalid;
    assign S_AXI_BRESP = s_q.bresp;
    assign S_AXI_ARREADY = !s_q.rvalid;
    assign S_AXI_RVALID = s_q.rvalid;
    assign S_AXI_RRESP = s_q.rresp;
    assign S_AXI_RDATA = {24'h000000, s_q.rdata};
    assign TX_CTRL = s_q.tx;
    assign SYNC_N_OUT = s_q.sync_n;
    assign LINK_UP = (s_q.link == LS_DATA);
    assign EOF_REPLACE = s_q.eof_rep;
    assign ILA_DID_VALID = s_q.did_valid;
    assign ILA_DID = s_q.did_out;
    assign IRQ = |(s_q.irq_sts & s_q.irq_mask);

    a_scramble_follow:
    assert property (@(posedge MCLK) disable iff (!RESETN)
        TX_CTRL.scramble == s_q.ctrl1[`SLTC_C1_SCR]) else $error("Scramble mismatch");

    a_frames_field:
    assert property (@(posedge MCLK) disable iff (!RESETN)
        FRAME_STROBE && s_q.ctrl1[`SLTC_C1_EN] && s_q.frame_cnt == TX_CTRL.k_m1
        |=> s_q.frame_cnt == 5'h00) else $error("Multiframe length wrong");

    a_rate_scale:
    assert property (@(posedge MCLK) disable iff (!RESETN)
        ##1 TX_CTRL.rate_q == (s_q.ctrl1[`SLTC_C1_RATE] ?
            (s_q.ctrl2[`SLTC_C2_P54] ? `SLTC_RATE_25X : `SLTC_RATE_2X) :
            (s_q.ctrl2[`SLTC_C2_P54] ? `SLTC_RATE_125X : `SLTC_RATE_1X)))
        else $error("Bit rate code wrong");

    a_disabled_held:
    assert property (@(posedge MCLK) disable iff (!RESETN)
        !s_q.ctrl1[`SLTC_C1_EN] |-> !TX_CTRL.tx_resetn && TX_CTRL.serdes_pd
        && !TX_CTRL.clk_gate_en ##1 !LINK_UP) else $error("Disabled link not held");

    a_sync_route:
    assert property (@(posedge MCLK) disable iff (!RESETN)
        $past(RESETN) |-> SYNC_N_OUT == ($past(s_q.ctrl2[`SLTC_C2_SSEL]) ?
            $past(SYNC_DIFFERENTIAL_N) : $past(SYNC_SINGLE_ENDED_N)))
        else $error("Sync routing wrong");

    a_test_reserved:
    assert property (@(posedge MCLK) disable iff (!RESETN)
        s_q.ctrl2[`SLTC_C2_TEST_HI:`SLTC_C2_TEST_LO] > `SLTC_TEST_LAST |-> TX_CTRL.test == TEST_OFF)
        else $error("Reserved test code leaked");

    a_did_window:
    assert property (@(posedge MCLK) disable iff (!RESETN)
        ILA_DID_VALID |-> s_q.link == LS_ILA && s_q.mf_cnt == `SLTC_DID_MF && ILA_DID == $past(s_q.did))
        else $error("Identifier outside second multiframe");

    a_link_up_only:
    assert property (@(posedge MCLK) disable iff (!RESETN)
        $rose(LINK_UP) |-> $past(s_q.link) == LS_ILA && $past(mf_end))
        else $error("Link up without alignment sequence");

    a_phase_set:
    assert property (@(posedge MCLK) disable iff (!RESETN)
        SYSREF && s_q.armed && s_q.ctrl1[`SLTC_C1_EN] |=> s_q.multiframe_phase_flag [*2] or
        (s_q.multiframe_phase_flag ##1 1'b1)) else $error("Phase flag not set");

    a_eof_char:
    assert property (@(posedge MCLK) disable iff (!RESETN)
        s_q.ctrl3[`SLTC_C3_FCH_HI:`SLTC_C3_FCH_LO] == `SLTC_FCH_K28_1 |-> TX_CTRL.eof_char == `SLTC_K28_1)
        else $error("Frame-end character wrong");

endmodule : sltc_top

`default_nettype wire

// *** verif/sltc_rx_model.sv ***
/*
 Behavioural model of the serial link receiver: sync request on the two
 sync lines and frame strobes with the last octet of each frame.
 Assumes one clock, MCLK, shared with the transmit control block.
*/
`timescale 1ns/10ps
`default_nettype none
module sltc_rx_model (
    input wire logic mclk,
    input wire logic req_n,
    input wire logic use_diff,
    input wire logic frame_en,
    input wire logic [7:0] octet,
    output logic sync_single_ended_n = 1'b1,
    output logic sync_differential_n = 1'b0,
    output logic frame_strobe = 1'b0,
    output logic [7:0] last_octet = 8'h00
);
    logic [1:0] div_q = 2'h0;
    // Unused sync line shows the inverse so a wrong route cannot pass
    always @(posedge mclk) begin
        sync_single_ended_n <= use_diff ? !req_n : req_n;
        sync_differential_n <= use_diff ? req_n : !req_n;
        div_q <= frame_en ? div_q + 2'h1 : 2'h0;
        frame_strobe <= frame_en && (div_q == 2'h3);
        // Octet is only meaningful with the strobe
        last_octet <= (frame_en && div_q == 2'h3) ? octet : ~octet;
    end
endmodule : sltc_rx_model
`default_nettype wire

// *** verif/tb_top.sv ***
/*
 Self-checking bench of the serial link transmit control block: AXI4-Lite
 register tasks, receiver model on the link side, one task per scenario.
 Assumes the package and register header are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sltc_regs.svh"
module tb_top;
    import sltc_pkg::*;
    localparam logic [11:0] A_C1 = {`SLTC_IDX_CTRL1, 2'b00};
    localparam logic [11:0] A_C2 = {`SLTC_IDX_CTRL2, 2'b00};
    localparam logic [11:0] A_DID = {`SLTC_IDX_DID, 2'b00};
    localparam logic [11:0] A_C3 = {`SLTC_IDX_CTRL3, 2'b00};
    localparam logic [11:0] A_ST = {`SLTC_IDX_STATUS, 2'b00};
    localparam logic [11:0] A_IS = {`SLTC_IDX_IRQ_STS, 2'b00};
    localparam logic [11:0] A_IM = {`SLTC_IDX_IRQ_MASK, 2'b00};
    localparam logic [1:0] OK = `SLTC_RESP_OKAY;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic sysref = 0, pll = 0, req_n = 0, use_diff = 0, frame_en = 0;
    logic [7:0] octet = 8'h11, lo, did;
    logic awready, wready, bvalid, arready, rvalid, sse, sdi, fs;
    logic sync_out, link_up, eof_rep, did_vld, irq;
    logic [1:0] bresp, rresp;
    sltc_tx_ctrl_t tx;
    int n_fail = 0;
    int samples_checked = 0;

    initial begin
        forever #25 clk = ~clk;
    end

    sltc_top i_sltc_top (.MCLK(clk), .RESETN(rst_n), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .SYNC_SINGLE_ENDED_N(sse), .SYNC_DIFFERENTIAL_N(sdi),
        .SYSREF(sysref), .PLL_LOCKED(pll), .FRAME_STROBE(fs), .LAST_OCTET(lo),
        .TX_CTRL(tx), .SYNC_N_OUT(sync_out), .LINK_UP(link_up), .EOF_REPLACE(eof_rep),
        .ILA_DID_VALID(did_vld), .ILA_DID(did), .IRQ(irq));

    sltc_rx_model i_sltc_rx_model (.mclk(clk), .req_n(req_n), .use_diff(use_diff),
        .frame_en(frame_en), .octet(octet), .sync_single_ended_n(sse), .sync_differential_n(sdi),
        .frame_strobe(fs), .last_octet(lo));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        bit aw;
        bit w;
        bit done;
        aw = 1'b0;
        w = 1'b0;
        done = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (bready && bvalid === 1'b1) begin
                done = 1'b1;
                bready <= 1'b0;
                chk({30'h0, bresp}, {30'h0, er}, "write response");
            end
            aw = aw || (awvalid && awready === 1'b1);
            w = w || (wvalid && wready === 1'b1);
            if (awvalid && aw) awvalid <= 1'b0;
            if (wvalid && w) wvalid <= 1'b0;
            if (aw && w && !done) bready <= 1'b1;
        end
    endtask : axw

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        bit done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (rready && rvalid === 1'b1) begin
                done = 1'b1;
                rready <= 1'b0;
                chk(rdata, exp, "read data");
                chk({30'h0, rresp}, {30'h0, er}, "read response");
            end else if (arvalid && arready === 1'b1) begin
                arvalid <= 1'b0;
                rready <= 1'b1;
            end
        end
    endtask : rdchk

    task automatic t_reset;
        rdchk(A_C1, 32'h0000000F, OK);
        rdchk(A_C2, 32'h0, OK);
        rdchk(A_DID, 32'h0, OK);
        rdchk(A_C3, 32'h0, OK);
        rdchk(A_ST, 32'h0, OK);
        chk(32'(tx.scramble), 32'h0, "scramble");
        chk(32'(tx.k_m1), 32'h3, "frames minus one");
        chk(32'(tx.rate_q), 32'h8, "rate");
        chk(32'(tx.tx_resetn), 32'h1, "tx reset");
        chk(32'(tx.eof_char), 32'(`SLTC_K28_7), "frame end");
        rdchk(12'h818, 32'h0, `SLTC_RESP_SLVERR);
        axw(12'h818, 8'hFF, `SLTC_RESP_SLVERR);
        $display("test reset done");
    endtask : t_reset

    task automatic t_rates;
        logic [3:0] exp_rate [4] = '{4'h4, 4'h8, 4'h5, 4'hA};
        axw(A_C1, 8'h0E, OK);
        cyc(3);
        chk(32'(tx.tx_resetn), 32'h0, "held in reset");
        chk(32'(tx.serdes_pd), 32'h1, "serializer down");
        chk(32'(tx.clk_gate_en), 32'h0, "clocks gated");
        for (int i = 0; i < 4; i++) begin
            axw(A_C1, {i[1], 5'h05, i[0], 1'b0}, OK);
            axw(A_C2, {i[1], 7'h00}, OK);
            cyc(3);
            chk(32'(tx.rate_q), 32'(exp_rate[i]), "rate");
            chk(32'(tx.scramble), 32'(i[1]), "scramble");
            chk(32'(tx.k_m1), 32'h5, "frames minus one");
        end
        $display("test rates done");
    endtask : t_rates

    task automatic t_codes;
        logic [7:0] efc [4] = '{`SLTC_K28_7, `SLTC_K28_1, `SLTC_K28_5, `SLTC_K28_7};
        for (int i = 0; i < 16; i++) begin
            axw(A_C2, 8'(i), OK);
            cyc(3);
            chk(32'(tx.test), (i < 12) ? i : 0, "test code");
        end
        for (int i = 0; i < 4; i++) begin
            axw(A_C3, 8'(i), OK);
            cyc(3);
            chk(32'(tx.eof_char), 32'(efc[i]), "frame end");
            rdchk(A_C3, i, OK);
        end
        // A write without byte strobe must leave the register alone
        wstrb <= 4'h0;
        axw(A_C3, 8'h01, OK);
        wstrb <= 4'hF;
        rdchk(A_C3, 32'h3, OK);
        axw(A_C3, 8'h00, OK);
        $display("test codes done");
    endtask : t_codes

    task automatic t_sync;
        req_n <= 1'b0;
        use_diff <= 1'b1;
        axw(A_C2, 8'h40, OK);
        cyc(4);
        chk(32'(sync_out), 32'h0, "differential sync");
        axw(A_C2, 8'h00, OK);
        cyc(4);
        chk(32'(sync_out), 32'h1, "single-ended sync");
        use_diff <= 1'b0;
        cyc(4);
        chk(32'(sync_out), 32'h0, "single-ended sync");
        $display("test sync done");
    endtask : t_sync

    task automatic t_link;
        int n;
        int cnt;
        pll <= 1'b1;
        axw(A_DID, 8'h5A, OK);
        axw(A_C1, 8'h0E, OK);
        axw(A_C1, 8'h0F, OK);
        frame_en <= 1'b1;
        cyc(10);
        req_n <= 1'b1;
        n = 0;
        while (did_vld !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        chk(32'(did_vld), 32'h1, "identifier slot");
        chk(32'(did), 32'h5A, "identifier");
        chk(32'(link_up), 32'h0, "link up early");
        n = 0;
        while (link_up !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        chk(32'(link_up), 32'h1, "link up");
        rdchk(A_ST, 32'h64, OK);
        // Constant octets: replacement must alternate, never two in a row
        cyc(8);
        cnt = 0;
        repeat (32) begin
            cyc(1);
            cnt += (eof_rep === 1'b1);
        end
        chk(cnt, 32'h4, "frame end replacements");
        axw(A_IM, 8'h01, OK);
        axw(A_IS, 8'h0F, OK);
        cyc(2);
        chk(32'(irq), 32'h0, "irq idle");
        sysref <= 1'b1;
        cyc(1);
        sysref <= 1'b0;
        cyc(3);
        chk(32'(irq), 32'h1, "irq raised");
        rdchk(A_ST, 32'h6C, OK);
        axw(A_IM, 8'h00, OK);
        cyc(2);
        chk(32'(irq), 32'h0, "irq masked");
        sysref <= 1'b1;
        cyc(1);
        sysref <= 1'b0;
        cyc(3);
        rdchk(A_ST, 32'h7C, OK);
        axw(A_ST, 8'h18, OK);
        rdchk(A_ST, 32'h64, OK);
        axw(A_IS, 8'h01, OK);
        axw(A_IM, 8'h01, OK);
        cyc(2);
        chk(32'(irq), 32'h0, "irq cleared");
        req_n <= 1'b0;
        cyc(12);
        chk(32'(link_up), 32'h0, "link down on sync");
        axw(A_C1, 8'h0E, OK);
        cyc(3);
        chk(32'(link_up), 32'h0, "link down disabled");
        chk(32'(tx.tx_resetn), 32'h0, "held in reset");
        // Scrambled data: every frame ending in the F octet is replaced
        axw(A_C1, 8'h8E, OK);
        octet <= `SLTC_F_DATA;
        axw(A_C1, 8'h8F, OK);
        req_n <= 1'b1;
        n = 0;
        while (link_up !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        cnt = 0;
        repeat (32) begin
            cyc(1);
            cnt += (eof_rep === 1'b1);
        end
        chk(cnt, 32'h8, "scrambled frame ends");
        $display("test link done");
    endtask : t_link

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        cyc(1);
        t_reset();
        t_rates();
        t_codes();
        t_sync();
        t_link();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("ERROR t=%0t watchdog expired", $time);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
